// ===== inc/two_wire_consts.svh
// timing counts and bus codes for the two-wire link
`ifndef TWO_WIRE_CONSTS_SVH
`define TWO_WIRE_CONSTS_SVH
`define TW_CLK_NS 100
`define TW_TIMEOUT_MS 30
`define TW_TIMEOUT_CYC ((`TW_TIMEOUT_MS * 1000000) / `TW_CLK_NS)
`define TW_HS_CODE_MASK 8'hf8
`define TW_HS_CODE 8'h08
`define TW_TOUT_EN_BIT 7
`define TW_CONSEC_RESET 8'h81
`define TW_DEV_ADDR 7'h2a
`define TW_MDIV 4
`endif

// ===== inc/two_wire_if.sv
// two-wire bus wires with open-drain resolution
`timescale 1ns/1ps
interface two_wire_if;
	logic sclOe;
	logic sdaMOut;
	logic sdaMOe;
	logic sdaSOut;
	logic sdaSOe;
	logic scl;
	logic sda;
	// enables are low while driving; released lines float high
	assign scl = sclOe ? 1'b1 : 1'b0;
	assign sda = (sdaMOe ? 1'b1 : sdaMOut) & (sdaSOe ? 1'b1 : sdaSOut);
	modport master (output sclOe, output sdaMOut, output sdaMOe, input scl, input sda);
	modport slave (output sdaSOut, output sdaSOe, input scl, input sda);
endinterface

// ===== inc/two_wire_pkg.sv
// types shared by both ends of the two-wire link
package two_wire_pkg;
	typedef enum logic [2:0] {
		SL_IDLE = 3'b000,
		SL_RXBIT = 3'b001,
		SL_ACK = 3'b010,
		SL_TXBIT = 3'b011,
		SL_MACK = 3'b100,
		SL_WAIT = 3'b101
	} slave_st_e;
	typedef enum logic [2:0] {
		MS_IDLE = 3'b000,
		MS_START = 3'b001,
		MS_BIT = 3'b010,
		MS_ACK = 3'b011,
		MS_STOP = 3'b100
	} master_st_e;
endpackage

// ===== logic/sync2.sv
// two-flop synchroniser for a level
`timescale 1ns/1ps
module sync2 #(
	parameter logic INIT = 1'b1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic d,
	output logic q
);
	logic meta_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= INIT;
			q <= INIT;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ===== logic/two_wire_master.sv
// master end of the two-wire link, making SCL from clk
`timescale 1ns/1ps
`include "two_wire_consts.svh"
module two_wire_master import two_wire_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	two_wire_if.master bus,
	input wire logic cmdValid,
	input wire logic cmdStart,
	input wire logic cmdStop,
	input wire logic cmdRead,
	input wire logic cmdNack,
	input wire logic [7:0] cmdData,
	output logic cmdReady,
	output logic [7:0] rspData,
	output logic rspAck,
	output logic rspValid
);
	typedef struct packed {
		master_st_e st;
		logic [1:0] div;
		logic [1:0] phase;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic rd;
		logic nack;
		logic stop;
		logic sclOut;
		logic sdaOut;
		logic ready;
		logic [7:0] rsp;
		logic ack;
		logic valid;
	} mst_s;
	mst_s m_r, m_nxt;
	logic sdaS;
	sync2 u_sda (.clk(clk), .rst_b(rst_b), .d(bus.sda), .q(sdaS));
	always_comb begin
		m_nxt = m_r;
		m_nxt.valid = 1'b0;
		m_nxt.div = m_r.div + 2'h1;
		if (m_r.st == MS_IDLE) begin
			m_nxt.ready = 1'b1;
			if (cmdValid && m_r.ready) begin
				m_nxt.ready = 1'b0;
				m_nxt.shift = cmdRead ? 8'hff : cmdData;
				m_nxt.rd = cmdRead;
				m_nxt.nack = cmdNack;
				m_nxt.stop = cmdStop;
				m_nxt.bitCnt = 4'h0;
				m_nxt.phase = 2'h0;
				m_nxt.div = 2'h0;
				m_nxt.st = cmdStart ? MS_START : MS_BIT;
			end
		end else if (m_r.div == 2'h3) begin
			m_nxt.phase = m_r.phase + 2'h1;
			case (m_r.st)
				MS_START: begin
					case (m_r.phase)
						2'h0: m_nxt.sdaOut = 1'b1;
						2'h1: m_nxt.sclOut = 1'b1;
						2'h2: m_nxt.sdaOut = 1'b0;
						default: begin
							m_nxt.sclOut = 1'b0;
							m_nxt.st = MS_BIT;
						end
					endcase
				end
				MS_BIT, MS_ACK: begin
					case (m_r.phase)
						2'h0: m_nxt.sdaOut = (m_r.st == MS_ACK) ? ~m_r.rd | m_r.nack : m_r.shift[7];
						2'h1: m_nxt.sclOut = 1'b1;
						2'h2: begin
							if (m_r.st == MS_BIT) begin
								m_nxt.shift = {m_r.shift[6:0], m_r.rd ? sdaS : 1'b1};
							end else begin
								m_nxt.ack = ~sdaS;
							end
						end
						default: begin
							m_nxt.sclOut = 1'b0;
							m_nxt.bitCnt = m_r.bitCnt + 4'h1;
							if (m_r.st == MS_ACK) begin
								m_nxt.rsp = m_r.shift;
								m_nxt.valid = 1'b1;
								m_nxt.sdaOut = 1'b1;
								m_nxt.st = m_r.stop ? MS_STOP : MS_IDLE;
							end else if (m_r.bitCnt == 4'h7) begin
								m_nxt.st = MS_ACK;
							end
						end
					endcase
				end
				MS_STOP: begin
					case (m_r.phase)
						2'h0: m_nxt.sdaOut = 1'b0;
						2'h1: m_nxt.sclOut = 1'b1;
						2'h2: m_nxt.sdaOut = 1'b1;
						default: m_nxt.st = MS_IDLE;
					endcase
				end
				default: m_nxt.st = MS_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			m_r <= '{st: MS_IDLE, div: 2'h0, phase: 2'h0, bitCnt: 4'h0, shift: 8'h00, rd: 1'b0,
				nack: 1'b0, stop: 1'b0, sclOut: 1'b1, sdaOut: 1'b1, ready: 1'b0, rsp: 8'h00,
				ack: 1'b0, valid: 1'b0};
		end else begin
			m_r <= m_nxt;
		end
	end
	assign bus.sclOe = m_r.sclOut;
	assign bus.sdaMOut = 1'b0;
	assign bus.sdaMOe = m_r.sdaOut;
	assign cmdReady = m_r.ready;
	assign rspData = m_r.rsp;
	assign rspAck = m_r.ack;
	assign rspValid = m_r.valid;
endmodule

// ===== logic/two_wire_slave.sv
// slave end of the two-wire link with register pointer and bus timeout
`timescale 1ns/1ps
`include "two_wire_consts.svh"
// Summary of operation
// - both lines high means bus idle
// - SDA falling with SCL high is START
// - SDA rising with SCL high is STOP
// - repeated START begins a new transfer
// - no limit on bytes per transfer
// - receiver holds SDA low during acknowledge
// - master not-acknowledge ends device read data
// - master sends high-speed code after START
// - high-speed code unacknowledged, filters go fast
// - slave address follows the high-speed code
// - STOP returns filters to fast mode
// - timeout active only while control bit set
// - line held low 30 ms resets interface
// - on timeout release bus, await START
// - master keeps SCL at least 1 kHz
// - timeout enabled after reset
// - first byte: seven-bit address plus direction
// - bytes travel most significant bit first
// - first written byte loads register pointer
// - pointer kept across transfers
module two_wire_slave import two_wire_pkg::*; #(
	parameter int TIMEOUT_CYC = `TW_TIMEOUT_CYC,
	parameter logic [6:0] DEV_ADDR = `TW_DEV_ADDR
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sclk,
	two_wire_if.slave bus,
	input wire logic [7:0] txData,
	output logic [7:0] pointer,
	output logic [7:0] rxData,
	output logic rxValid,
	output logic hsMode,
	output logic timeoutEn,
	output logic busActive
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		slave_st_e st;
		logic sclQ;
		logic sdaQ;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic first;
		logic ptrNext;
		logic isRead;
		logic hsByte;
		logic sdaOut;
		logic [7:0] ptr;
		logic ptrTgl;
		logic [7:0] rx;
		logic rxTgl;
		logic hs;
		logic active;
		logic [7:0] consec;
	} slv_s;
	slv_s s_r, s_nxt;
	logic sclS, sdaS;
	logic [31:0] lowCnt_r;
	logic toutTgl_r, toutSeen_r;
	logic toutS, toutSQ_r;
	logic rxTglS, rxTglQ_r;
	logic ptrTglS, ptrTglQ_r, hsC, toutEnC;
	logic rise, fall, startC, stopC;
	// ----------------------------------------
	// link domain: sampled lines, bit engine
	// ----------------------------------------
	sync2 u_scl (.clk(sclk), .rst_b(rst_b), .d(bus.scl), .q(sclS));
	sync2 u_sda (.clk(sclk), .rst_b(rst_b), .d(bus.sda), .q(sdaS));
	sync2 #(.INIT(1'b0)) u_to (.clk(sclk), .rst_b(rst_b), .d(toutTgl_r), .q(toutS));
	always_comb begin
		rise = sclS & ~s_r.sclQ;
		fall = ~sclS & s_r.sclQ;
		startC = sclS & s_r.sclQ & s_r.sdaQ & ~sdaS;
		stopC = sclS & s_r.sclQ & ~s_r.sdaQ & sdaS;
		s_nxt = s_r;
		s_nxt.sclQ = sclS;
		s_nxt.sdaQ = sdaS;
		if (toutS != toutSQ_r) begin
			s_nxt.st = SL_WAIT;
			s_nxt.sdaOut = 1'b1;
			s_nxt.active = 1'b0;
		end else if (startC) begin
			s_nxt.st = SL_RXBIT;
			s_nxt.bitCnt = 4'h0;
			s_nxt.first = 1'b1;
			s_nxt.sdaOut = 1'b1;
			s_nxt.active = 1'b1;
		end else if (stopC) begin
			s_nxt.st = SL_IDLE;
			s_nxt.sdaOut = 1'b1;
			s_nxt.hs = 1'b0;
			s_nxt.active = 1'b0;
		end else begin
			case (s_r.st)
				SL_IDLE, SL_WAIT: begin
					s_nxt.sdaOut = 1'b1;
				end
				SL_RXBIT: begin
					if (rise) begin
						s_nxt.shift = {s_r.shift[6:0], sdaS};
						s_nxt.bitCnt = s_r.bitCnt + 4'h1;
					end
					if (fall && s_r.bitCnt == 4'h8) begin
						s_nxt.bitCnt = 4'h0;
						s_nxt.st = SL_ACK;
						s_nxt.first = 1'b0;
						if (s_r.first && (s_r.shift & `TW_HS_CODE_MASK) == `TW_HS_CODE) begin
							s_nxt.hs = 1'b1;
							s_nxt.hsByte = 1'b1;
						end else if (s_r.first && s_r.shift[7:1] == DEV_ADDR) begin
							s_nxt.sdaOut = 1'b0;
							s_nxt.isRead = s_r.shift[0];
							s_nxt.ptrNext = ~s_r.shift[0];
						end else if (s_r.first) begin
							s_nxt.st = SL_WAIT;
						end else begin
							s_nxt.sdaOut = 1'b0;
							if (s_r.ptrNext) begin
								s_nxt.ptr = s_r.shift;
								s_nxt.ptrTgl = ~s_r.ptrTgl;
								s_nxt.ptrNext = 1'b0;
							end else begin
								s_nxt.rx = s_r.shift;
								s_nxt.rxTgl = ~s_r.rxTgl;
							end
						end
					end
				end
				SL_ACK: begin
					if (fall) begin
						s_nxt.sdaOut = 1'b1;
						if (s_r.hsByte) begin
							s_nxt.hsByte = 1'b0;
							s_nxt.first = 1'b1;
							s_nxt.st = SL_RXBIT;
						end else if (s_r.isRead) begin
							s_nxt.st = SL_TXBIT;
							s_nxt.shift = {txData[6:0], 1'b0};
							s_nxt.sdaOut = txData[7];
							s_nxt.bitCnt = 4'h1;
						end else begin
							s_nxt.st = SL_RXBIT;
						end
					end
				end
				SL_TXBIT: begin
					if (fall) begin
						if (s_r.bitCnt == 4'h8) begin
							s_nxt.sdaOut = 1'b1;
							s_nxt.st = SL_MACK;
						end else begin
							s_nxt.sdaOut = s_r.shift[7];
							s_nxt.shift = {s_r.shift[6:0], 1'b0};
							s_nxt.bitCnt = s_r.bitCnt + 4'h1;
						end
					end
				end
				SL_MACK: begin
					if (rise) begin
						if (sdaS) begin
							s_nxt.st = SL_WAIT;
						end else begin
							s_nxt.st = SL_ACK;
						end
					end
				end
				default: s_nxt.st = SL_IDLE;
			endcase
		end
	end
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{st: SL_IDLE, sclQ: 1'b1, sdaQ: 1'b1, bitCnt: 4'h0, shift: 8'h00, first: 1'b0,
				ptrNext: 1'b0, isRead: 1'b0, hsByte: 1'b0, sdaOut: 1'b1, ptr: 8'h00, ptrTgl: 1'b0, rx: 8'h00,
				rxTgl: 1'b0, hs: 1'b0, active: 1'b0, consec: `TW_CONSEC_RESET};
			toutSQ_r <= 1'b0;
		end else begin
			s_r <= s_nxt;
			toutSQ_r <= toutS;
		end
	end
	// SCL idles stopped, so the ack clears only on a following edge
	assign bus.sdaSOut = 1'b0;
	assign bus.sdaSOe = s_r.sdaOut;
	// ----------------------------------------
	// system domain: timeout counter and crossings of received data, pointer and status
	// ----------------------------------------
	logic sclC, sdaC, actC;
	sync2 u_sc (.clk(clk), .rst_b(rst_b), .d(bus.scl), .q(sclC));
	sync2 u_dc (.clk(clk), .rst_b(rst_b), .d(bus.sda), .q(sdaC));
	sync2 #(.INIT(1'b0)) u_ac (.clk(clk), .rst_b(rst_b), .d(s_r.active), .q(actC));
	sync2 #(.INIT(1'b0)) u_rt (.clk(clk), .rst_b(rst_b), .d(s_r.rxTgl), .q(rxTglS));
	sync2 #(.INIT(1'b0)) u_pt (.clk(clk), .rst_b(rst_b), .d(s_r.ptrTgl), .q(ptrTglS));
	sync2 #(.INIT(1'b0)) u_hs (.clk(clk), .rst_b(rst_b), .d(s_r.hs), .q(hsC));
	sync2 #(.INIT(1'b1)) u_te (.clk(clk), .rst_b(rst_b), .d(s_r.consec[`TW_TOUT_EN_BIT]), .q(toutEnC));
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowCnt_r <= 32'h0;
			toutTgl_r <= 1'b0;
			toutSeen_r <= 1'b0;
			rxTglQ_r <= 1'b0;
			ptrTglQ_r <= 1'b0;
			rxValid <= 1'b0;
			rxData <= 8'h00;
			pointer <= 8'h00;
			hsMode <= 1'b0;
			timeoutEn <= 1'b1;
			busActive <= 1'b0;
		end else begin
			rxTglQ_r <= rxTglS;
			ptrTglQ_r <= ptrTglS;
			rxValid <= rxTglS ^ rxTglQ_r;
			// words are taken only once their toggle has crossed
			if (rxTglS ^ rxTglQ_r) begin
				rxData <= s_r.rx;
			end
			if (ptrTglS ^ ptrTglQ_r) begin
				pointer <= s_r.ptr;
			end
			hsMode <= hsC;
			timeoutEn <= toutEnC;
			busActive <= actC;
			if (!actC) begin
				toutSeen_r <= 1'b0;
			end
			if (toutEnC && actC && (!sclC || !sdaC) && !toutSeen_r) begin
				if (lowCnt_r >= 32'(TIMEOUT_CYC - 1)) begin
					toutTgl_r <= ~toutTgl_r;
					toutSeen_r <= 1'b1;
					lowCnt_r <= 32'h0;
				end else begin
					lowCnt_r <= lowCnt_r + 32'h1;
				end
			end else begin
				lowCnt_r <= 32'h0;
			end
		end
	end
endmodule

// ===== tb/two_wire_chk.sv
// assertions on the two-wire link between master and slave ends
`timescale 1ns/1ps
module two_wire_chk #(
	parameter int TIMEOUT_CYC = 200
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda,
	input wire logic sdaSOe,
	input wire logic busActive,
	input wire logic hsMode,
	input wire logic timeoutEn
);
	localparam int TOUT2 = 2 * TIMEOUT_CYC;
	logic [15:0] lowCnt_r;
	// ----
	// clock-low counter
	// ----
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowCnt_r <= 16'h0000;
		end else if (scl) begin
			lowCnt_r <= 16'h0000;
		end else if (lowCnt_r != 16'hffff) begin
			lowCnt_r <= lowCnt_r + 16'h0001;
		end
	end
	// ----
	// properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_idle; (!busActive)[*4] |-> sdaSOe; endproperty
	property p_start; $fell(sda) && scl |-> ##[1:20] busActive; endproperty
	property p_stop; $rose(sda) && scl |-> ##[1:20] !busActive; endproperty
	property p_hsoff; $rose(sda) && scl |-> ##[1:20] !hsMode; endproperty
	property p_hsidle; (!busActive)[*4] |-> !hsMode; endproperty
	property p_ackhold; scl && $past(scl) |-> $stable(sdaSOe); endproperty
	property p_toen; timeoutEn; endproperty
	property p_tout; lowCnt_r == TOUT2 |-> sdaSOe; endproperty
	a_idle: assert property (p_idle) else $error("slave drives while idle");
	a_start: assert property (p_start) else $error("start missed");
	a_stop: assert property (p_stop) else $error("stop missed");
	a_hsoff: assert property (p_hsoff) else $error("fast filters kept after stop");
	a_hsidle: assert property (p_hsidle) else $error("fast filters while idle");
	a_ackhold: assert property (p_ackhold) else $error("slave sda moved with scl high");
	a_toen: assert property (p_toen) else $error("timeout disabled");
	a_tout: assert property (p_tout) else $error("bus held after timeout");
	c_start: cover property ($fell(sda) && scl);
	c_hs: cover property ($rose(hsMode));
	c_tout: cover property (lowCnt_r == TOUT2);
endmodule

// ===== tb/two_wire_slave_interface_tb_top.sv
// testbench joining master and slave ends over the two-wire link
`timescale 1ns/1ps
module two_wire_slave_interface_tb_top;
	localparam int TOUT = 200;
	logic clk = 1'b0;
	logic sclk = 1'b0;
	logic rst_b = 1'b0;
	logic cmdValid = 1'b0;
	logic [3:0] cmdFlags = 4'h0;
	logic [7:0] cmdData = 8'h00;
	logic [7:0] txData = 8'h96;
	logic cmdReady, rspAck, rspValid, rxValid, hsMode, timeoutEn, busActive;
	logic [7:0] rspData, pointer, rxData;
	logic [7:0] rxCnt = 8'h00;
	int errorCnt = 0;
	int checksDone = 0;
	two_wire_if tw();
	// ----
	// ends and checker
	// ----
	two_wire_slave #(.TIMEOUT_CYC(TOUT)) i_two_wire_slave (.clk(clk), .rst_b(rst_b), .sclk(sclk), .bus(tw.slave),
		.txData(txData), .pointer(pointer), .rxData(rxData), .rxValid(rxValid), .hsMode(hsMode),
		.timeoutEn(timeoutEn), .busActive(busActive));
	two_wire_master i_two_wire_master (.clk(clk), .rst_b(rst_b), .bus(tw.master), .cmdValid(cmdValid),
		.cmdStart(cmdFlags[3]), .cmdStop(cmdFlags[2]), .cmdRead(cmdFlags[1]), .cmdNack(cmdFlags[0]),
		.cmdData(cmdData), .cmdReady(cmdReady), .rspData(rspData), .rspAck(rspAck), .rspValid(rspValid));
	two_wire_chk #(.TIMEOUT_CYC(TOUT)) i_two_wire_chk (.clk(clk), .rst_b(rst_b), .scl(tw.scl), .sda(tw.sda),
		.sdaSOe(tw.sdaSOe), .busActive(busActive), .hsMode(hsMode), .timeoutEn(timeoutEn));
	initial begin
		forever #50 clk = ~clk;
	end
	// counts received data bytes
	always @(posedge clk) begin
		if (rxValid === 1'b1) begin
			rxCnt <= rxCnt + 8'h01;
		end
	end
	initial begin
		#13;
		forever #40 sclk = ~sclk;
	end
	// ----
	// tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic closeOut;
		$display("errors %0d checks %0d", errorCnt, checksDone);
		if (errorCnt == 0 && checksDone > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// flags: start, stop, read, nack
	task automatic xb(input logic [3:0] f, input logic [7:0] d, input logic a);
		int n = 0;
		while (cmdReady !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		cmdFlags <= f;
		cmdData <= d;
		cmdValid <= 1'b1;
		@(posedge clk);
		cmdValid <= 1'b0;
		while (rspValid !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, rspValid}, 8'h01);
		if (!f[1]) begin
			chk({7'h00, rspAck}, {7'h00, a});
		end
	endtask
	// ----
	// tests
	// ----
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(negedge clk);
		chk({7'h00, timeoutEn}, 8'h01);
		xb(4'h8, 8'h54, 1'b1);
		chk({7'h00, busActive}, 8'h01);
		xb(4'h0, 8'h5a, 1'b1);
		xb(4'h0, 8'h3c, 1'b1);
		chk(rxData, 8'h3c);
		xb(4'h4, 8'ha5, 1'b1);
		chk(rxData, 8'ha5);
		chk(pointer, 8'h5a);
		repeat (40) @(negedge clk);
		chk({7'h00, busActive}, 8'h00);
		xb(4'h8, 8'h54, 1'b1);
		xb(4'h0, 8'hc3, 1'b1);
		xb(4'h8, 8'h55, 1'b1);
		xb(4'h2, 8'h00, 1'b0);
		chk(rspData, 8'h96);
		xb(4'h7, 8'h00, 1'b0);
		chk(rspData, 8'h96);
		chk({7'h00, tw.sdaSOe}, 8'h01);
		xb(4'h8, 8'h55, 1'b1);
		xb(4'h7, 8'h00, 1'b0);
		chk(pointer, 8'hc3);
		xb(4'hc, 8'h20, 1'b0);
		xb(4'h8, 8'h08, 1'b0);
		chk({7'h00, hsMode}, 8'h01);
		xb(4'h0, 8'h54, 1'b1);
		xb(4'h4, 8'h11, 1'b1);
		repeat (40) @(negedge clk);
		chk({7'h00, hsMode}, 8'h00);
		chk(pointer, 8'h11);
		@(posedge clk);
		txData <= 8'h4b;
		xb(4'h8, 8'h55, 1'b1);
		repeat (3 * TOUT) @(negedge clk);
		chk({7'h00, tw.sdaSOe}, 8'h01);
		xb(4'h8, 8'h54, 1'b1);
		xb(4'h4, 8'h22, 1'b1);
		chk(pointer, 8'h22);
		chk(rxCnt, 8'h02);
		closeOut();
	end
	initial begin
		#3000000;
		errorCnt++;
		$display("wrong value at %0t: watchdog expired", $time);
		closeOut();
	end
endmodule
